// file: shared/ustore_pkg.sv
// Constants, codes and carriers for the shift and store output stage.
// Assumes a single clock domain and a 32-bit AXI4-Lite register bus.
// U-Bus bit 0 (most significant in the microcode view) is vector bit 15.

package ustore_pkg;

  // ***************************************************************
  // Widths and field positions
  // ***************************************************************
  localparam int DATA_W      = 16;
  localparam int LOOP_COUNTER_REG_W      = 6;
  localparam int CTR_HI_LSB  = 6;
  localparam int CTR_LO_LSB  = 0;
  localparam int IO_CMD_LSB  = 8;
  localparam int IO_CMD_W    = 3;
  localparam int IO_DEV_LSB  = 0;
  localparam int IO_DEV_W    = 8;
  localparam int IO_SVC_BIT  = 15;
  localparam int STK_SEL_LSB = 0;
  localparam int TOS_N       = 4;
  localparam int ADDR_W      = 8;

  // ***************************************************************
  // Register byte offsets
  // ***************************************************************
  localparam logic [7:0] REG_SCRATCH0   = 8'h00;
  localparam logic [7:0] REG_SCRATCH1   = 8'h04;
  localparam logic [7:0] REG_ADDR_CODE  = 8'h08;
  localparam logic [7:0] REG_DATA_CODE  = 8'h0c;
  localparam logic [7:0] REG_COUNTER    = 8'h10;
  localparam logic [7:0] REG_DATA_BASE  = 8'h14;
  localparam logic [7:0] REG_DATA_LIMIT = 8'h18;
  localparam logic [7:0] REG_PROG_LIMIT = 8'h1c;
  localparam logic [7:0] REG_DIRECT_OUT = 8'h20;
  localparam logic [7:0] REG_TOS0       = 8'h24;
  localparam logic [7:0] REG_TOS1       = 8'h28;
  localparam logic [7:0] REG_TOS2       = 8'h2c;
  localparam logic [7:0] REG_TOS3       = 8'h30;
  localparam logic [7:0] REG_IO_STAT    = 8'h34;
  localparam logic [7:0] REG_STACK_STAT = 8'h38;
  localparam logic [7:0] REG_PCLK       = 8'h3c;
  localparam logic [7:0] REG_SBUS       = 8'h40;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ***************************************************************
  // Microinstruction field codes
  // ***************************************************************
  typedef enum logic [2:0] {
    right_to_left_zero_right = 3'h5,
    left_to_right_zero_left  = 3'h0,
    left_keep_zero_right     = 3'h1,
    shift_left_one           = 3'h2,
    shift_right_one          = 3'h3,
    right_keep_zero_left     = 3'h4,
    byte_exchange            = 3'h6,
    shift_pass               = 3'h7
  } shift_e;

  typedef enum logic [4:0] {
    st_pclk               = 5'h00,
    io_command_send       = 5'h01,
    io_word_send          = 5'h02,
    stack_cache_store     = 5'h03,
    bus_to_scratch1       = 5'h04,
    bus_to_scratch0       = 5'h05,
    st_bus_code           = 5'h07,
    st_push               = 5'h08,
    st_prog_limit         = 5'h09,
    counter_load_low      = 5'h0e,
    counter_load_high     = 5'h0f,
    st_data_base          = 5'h13,
    st_data_limit         = 5'h1c,
    st_nop                = 5'h1f
  } store_e;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic              valid;
    shift_e            shift;
    store_e            store;
    logic              mcu_data;
    logic [1:0]        stack_name;
    logic [1:0]        tos_ref;
    logic [DATA_W-1:0] t_bus;
  } uinstr_s;

  typedef struct packed {
    logic [DATA_W-1:0]   u_bus;
    logic [DATA_W-1:0]   addr_code;
    logic [DATA_W-1:0]   data_code;
    logic [LOOP_COUNTER_REG_W-1:0]   loop_counter_reg;
    logic [DATA_W-1:0]   data_base_reg;
    logic [DATA_W-1:0]   data_limit_reg;
    logic [DATA_W-1:0]   program_limit_reg;
    logic [DATA_W-1:0]   direct_output_data_reg;
    logic [IO_CMD_W-1:0] io_cmd;
    logic [IO_DEV_W-1:0] io_dev;
    logic                io_strobe;
    logic                service_out;
    logic [DATA_W-1:0]   sbus;
    logic [DATA_W-1:0]   tos_read;
    logic                special_off;
    logic                mcu_on;
  } stage_out_s;

endpackage

// file: design/ustore_stage.sv
// Shift and store output stage of a 16-bit microprogrammed datapath.
// Assumes the microsequencer presents one decoded microinstruction per
// enabled clock with valid high, and software uses AXI4-Lite.
// Function
// - Shift 111 passes the T-Bus word unchanged.
// - Shift 001 keeps left byte left, zeroes right byte.
// - Shift 000 moves left byte right, zeroes left byte.
// - Shift 101 moves right byte left, zeroes right byte.
// - Shift 110 exchanges the two bytes.
// - Shift 100 keeps right byte right, zeroes left byte.
// - Shift 010 shifts the word left one bit.
// - Shift 011 shifts the word logically right one bit.
// - Store 00101 writes scratch 0 and selected code register.
// - Store 00100 does the same using scratch 1.
// - Store 00111 does the same writing no scratch register.
// - Store 01111 loads U-Bus bits 4-9 into the counter.
// - Store 01110 loads U-Bus bits 10-15 into the counter.
// - Store 10011 writes the data base register.
// - Store 11100 writes the data limit register.
// - Store 01001 writes the program limit register.
// - Store 00001 sends an I/O command, optionally service-out.
// - Store 00010 writes the direct output data register.
// - Store 00011 writes the stack register picked by name plus SP1.
// - The next stack reference resolves through that selector.
// - Store 01000 pushes the word, moving elements down.
// - Store 00000 copies the process clock to the S-Bus register.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.

`timescale 1ns/1ps
`default_nettype none

module ustore_stage
  import ustore_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Microinstruction from the sequencer.
  input  wire uinstr_s           ui,
  // Datapath results.
  output var  stage_out_s        stage_out,
  // AXI4-Lite write address and data.
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response.
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read.
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    stage_out_s                    o;
    logic [DATA_W-1:0]             scratch_pad_0;
    logic [DATA_W-1:0]             scratch_pad_1;
    logic [TOS_N-1:0][DATA_W-1:0]  top_of_stack_regs;
    logic [1:0]                    effective_stack_select;
    logic                          stack_cache_store_last;
    logic [DATA_W-1:0]             pclk;
    logic                          aw_full;
    logic [ADDR_W-1:0]             awaddr;
    logic                          w_full;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic [DATA_W-1:0] u_now;
  logic [1:0]        eff_now;
  logic              step;

  // ***************************************************************
  // Functions
  // ***************************************************************
  function automatic logic [DATA_W-1:0] shift_word(
    input shift_e            c,
    input logic [DATA_W-1:0] t
  );
    case (c)
      shift_pass:               return t;
      left_keep_zero_right:     return {t[15:8], 8'h00};
      left_to_right_zero_left:  return {8'h00, t[15:8]};
      right_to_left_zero_right: return {t[7:0], 8'h00};
      byte_exchange:            return {t[7:0], t[15:8]};
      right_keep_zero_left:     return {8'h00, t[7:0]};
      shift_left_one:           return {t[14:0], 1'b0};
      default:                  return {1'b0, t[15:1]};
    endcase
  endfunction

  function automatic logic [31:0] widen(input logic [DATA_W-1:0] v);
    return {16'h0000, v};
  endfunction

  // ***************************************************************
  // Next state
  // ***************************************************************
  assign step    = ce && ui.valid;
  assign u_now   = shift_word(ui.shift, ui.t_bus);
  assign eff_now = ui.stack_name + s_q.scratch_pad_1[STK_SEL_LSB +: 2];

  assign s_axi_awready = ce && !s_q.aw_full && !s_q.bvalid;
  assign s_axi_wready  = ce && !s_q.w_full && !s_q.bvalid;
  assign s_axi_arready = ce && !s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign stage_out     = s_q.o;

  always_comb
  begin
    s_d = s_q;
    s_d.o.io_strobe   = 1'b0;
    s_d.o.service_out = 1'b0;
    s_d.o.special_off = 1'b0;
    s_d.o.mcu_on      = 1'b0;
    if (step)
    begin
      s_d.o.u_bus = u_now;
      // A stack reference in this word follows the selector of a
      // preceding stack-cache store, otherwise its own tos_ref field.
      if (s_q.stack_cache_store_last)
        s_d.o.tos_read = s_q.top_of_stack_regs[s_q.effective_stack_select];
      else
        s_d.o.tos_read = s_q.top_of_stack_regs[ui.tos_ref];
      s_d.stack_cache_store_last = 1'b0;
      case (ui.store)
        bus_to_scratch0, bus_to_scratch1, st_bus_code:
        begin
          if (ui.store == bus_to_scratch0)
            s_d.scratch_pad_0 = u_now;
          if (ui.store == bus_to_scratch1)
            s_d.scratch_pad_1 = u_now;
          if (ui.mcu_data)
            s_d.o.data_code = u_now;
          else
            s_d.o.addr_code = u_now;
          s_d.o.special_off = 1'b1;
          s_d.o.mcu_on      = 1'b1;
        end
        counter_load_high:
          s_d.o.loop_counter_reg = u_now[CTR_HI_LSB +: LOOP_COUNTER_REG_W];
        counter_load_low:
          s_d.o.loop_counter_reg = u_now[CTR_LO_LSB +: LOOP_COUNTER_REG_W];
        st_data_base:
          s_d.o.data_base_reg = u_now;
        st_data_limit:
          s_d.o.data_limit_reg = u_now;
        st_prog_limit:
          s_d.o.program_limit_reg = u_now;
        io_command_send:
        begin
          s_d.o.io_cmd      = u_now[IO_CMD_LSB +: IO_CMD_W];
          s_d.o.io_dev      = u_now[IO_DEV_LSB +: IO_DEV_W];
          s_d.o.io_strobe   = 1'b1;
          s_d.o.service_out = u_now[IO_SVC_BIT];
        end
        io_word_send:
          s_d.o.direct_output_data_reg = u_now;
        stack_cache_store:
        begin
          s_d.top_of_stack_regs[eff_now]              = u_now;
          s_d.effective_stack_select    = eff_now;
          s_d.stack_cache_store_last                 = 1'b1;
        end
        st_push:
          s_d.top_of_stack_regs = {s_q.top_of_stack_regs[TOS_N-2:0], u_now};
        st_pclk:
          s_d.o.sbus = s_q.pclk;
        default:
        begin
          // No-operation and codes handled elsewhere store nothing.
          s_d.stack_cache_store_last = 1'b0;
        end
      endcase
    end

    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_full = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_full = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    if (ce && s_q.aw_full && s_q.w_full && !s_q.bvalid)
    begin
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_DECERR;
      if (s_q.awaddr == REG_PCLK)
      begin
        s_d.bresp = RESP_OKAY;
        if (s_q.wstrb[0])
          s_d.pclk[7:0] = s_q.wdata[7:0];
        if (s_q.wstrb[1])
          s_d.pclk[15:8] = s_q.wdata[15:8];
      end
      else if (s_q.awaddr <= REG_SBUS && s_q.awaddr[1:0] == 2'h0)
        s_d.bresp = RESP_OKAY;
    end
    if (ce && s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;

    // Read channel.
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      if (s_axi_araddr == REG_SCRATCH0)
        s_d.rdata = widen(s_q.scratch_pad_0);
      else if (s_axi_araddr == REG_SCRATCH1)
        s_d.rdata = widen(s_q.scratch_pad_1);
      else if (s_axi_araddr == REG_ADDR_CODE)
        s_d.rdata = widen(s_q.o.addr_code);
      else if (s_axi_araddr == REG_DATA_CODE)
        s_d.rdata = widen(s_q.o.data_code);
      else if (s_axi_araddr == REG_COUNTER)
        s_d.rdata = {26'h0000000, s_q.o.loop_counter_reg};
      else if (s_axi_araddr == REG_DATA_BASE)
        s_d.rdata = widen(s_q.o.data_base_reg);
      else if (s_axi_araddr == REG_DATA_LIMIT)
        s_d.rdata = widen(s_q.o.data_limit_reg);
      else if (s_axi_araddr == REG_PROG_LIMIT)
        s_d.rdata = widen(s_q.o.program_limit_reg);
      else if (s_axi_araddr == REG_DIRECT_OUT)
        s_d.rdata = widen(s_q.o.direct_output_data_reg);
      else if (s_axi_araddr == REG_TOS0)
        s_d.rdata = widen(s_q.top_of_stack_regs[0]);
      else if (s_axi_araddr == REG_TOS1)
        s_d.rdata = widen(s_q.top_of_stack_regs[1]);
      else if (s_axi_araddr == REG_TOS2)
        s_d.rdata = widen(s_q.top_of_stack_regs[2]);
      else if (s_axi_araddr == REG_TOS3)
        s_d.rdata = widen(s_q.top_of_stack_regs[3]);
      else if (s_axi_araddr == REG_IO_STAT)
        s_d.rdata = {21'h000000, s_q.o.io_cmd, s_q.o.io_dev};
      else if (s_axi_araddr == REG_STACK_STAT)
        s_d.rdata = {29'h00000000, s_q.stack_cache_store_last,
                     s_q.effective_stack_select};
      else if (s_axi_araddr == REG_PCLK)
        s_d.rdata = widen(s_q.pclk);
      else if (s_axi_araddr == REG_SBUS)
        s_d.rdata = widen(s_q.o.sbus);
      else
      begin
        s_d.rdata = 32'h00000000;
        s_d.rresp = RESP_DECERR;
      end
    end
    if (ce && s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence shift_issue(logic [2:0] c);
    ce && ui.valid && ui.shift == c;
  endsequence

  sequence store_issue(logic [4:0] c);
    ce && ui.valid && ui.store == c;
  endsequence

  pass_through_a: assert property (
    shift_issue(shift_pass) |=> s_q.o.u_bus == $past(ui.t_bus))
    else $error("pass code altered the word");

  left_keep_a: assert property (
    shift_issue(left_keep_zero_right) |=>
      s_q.o.u_bus == {$past(ui.t_bus[15:8]), 8'h00})
    else $error("left keep result wrong");

  byte_swap_a: assert property (
    shift_issue(byte_exchange) |=>
      s_q.o.u_bus[7:0] == $past(ui.t_bus[15:8]) &&
      s_q.o.u_bus[15:8] == $past(ui.t_bus[7:0]))
    else $error("byte exchange wrong");

  shift_right_a: assert property (
    shift_issue(shift_right_one) |=>
      s_q.o.u_bus == ($past(ui.t_bus) >> 1))
    else $error("right shift wrong");

  scratch_code_a: assert property (
    store_issue(bus_to_scratch0) ##0 !ui.mcu_data |=>
      s_q.scratch_pad_0 == $past(u_now) &&
      s_q.o.addr_code == $past(u_now) && s_q.o.mcu_on)
    else $error("scratch 0 store wrong");

  counter_high_a: assert property (
    store_issue(counter_load_high) |=>
      s_q.o.loop_counter_reg == $past(u_now[11:6]))
    else $error("counter high load wrong");

  io_service_a: assert property (
    store_issue(io_command_send) |=>
      s_q.o.io_strobe && s_q.o.service_out == $past(u_now[15]) &&
      s_q.o.io_dev == $past(u_now[7:0]))
    else $error("io command wrong");

  stack_target_a: assert property (
    store_issue(stack_cache_store) |=>
      s_q.effective_stack_select ==
        2'($past(ui.stack_name) + $past(s_q.scratch_pad_1[1:0])) &&
      s_q.top_of_stack_regs[s_q.effective_stack_select] == $past(u_now) && s_q.stack_cache_store_last)
    else $error("stack cache store wrong");

  push_move_a: assert property (
    store_issue(st_push) |=>
      s_q.top_of_stack_regs[0] == $past(u_now) && s_q.top_of_stack_regs[1] == $past(s_q.top_of_stack_regs[0]) &&
      s_q.top_of_stack_regs[3] == $past(s_q.top_of_stack_regs[2]))
    else $error("push wrong");

  pclk_copy_a: assert property (
    store_issue(st_pclk) |=> s_q.o.sbus == $past(s_q.pclk))
    else $error("process clock copy wrong");

  nop_keep_a: assert property (
    store_issue(st_nop) |=> $stable(s_q.top_of_stack_regs) &&
      $stable(s_q.scratch_pad_0) && $stable(s_q.o.data_base_reg) &&
      !s_q.o.io_strobe)
    else $error("no-operation changed state");

endmodule

`default_nettype wire

// file: test/useq_model.sv
// Sequencer model that presents one microinstruction word per request.
// Assumes the bench raises go for one cycle with the word in cmd.

`timescale 1ns/1ps
`default_nettype none

module useq_model
  import ustore_pkg::*;
(
  // Clock and reset.
  input  wire logic    clk,
  input  wire logic    rst_n,
  // Request from the bench.
  input  wire logic    go,
  input  wire uinstr_s cmd,
  // Word to the stage.
  output var  uinstr_s ui
);

  // The word is held for exactly one cycle; afterwards the T-Bus toggles
  // so a stage that samples late sees a different value.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ui <= '0;
    end
    else if (go)
    begin
      ui       <= cmd;
      ui.valid <= 1'b1;
    end
    else
    begin
      ui.valid <= 1'b0;
      ui.t_bus <= ~ui.t_bus;
    end
  end

endmodule

`default_nettype wire

// file: test/microcode_shift_store_stage_tb.sv
// Self-checking bench for the shift and store output stage.
// Assumes the sequencer model in useq_model and AXI4-Lite register access.

`timescale 1ns/1ps
`default_nettype none

module microcode_shift_store_stage_tb
  import ustore_pkg::*;
;
  typedef struct packed {
    shift_e      sh;
    logic [15:0] t;
    logic [15:0] u;
  } row_s;

  localparam row_s ROWS [8] = '{
    '{shift_pass,               16'ha5c3, 16'ha5c3},
    '{left_keep_zero_right,     16'ha5c3, 16'ha500},
    '{left_to_right_zero_left,  16'ha5c3, 16'h00a5},
    '{right_to_left_zero_right, 16'ha5c3, 16'hc300},
    '{byte_exchange,            16'ha5c3, 16'hc3a5},
    '{right_keep_zero_left,     16'ha5c3, 16'h00c3},
    '{shift_left_one,           16'ha5c3, 16'h4b86},
    '{shift_right_one,          16'ha5c3, 16'h52e1}};

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic go = 1'b0;
  uinstr_s cmd = '0;
  uinstr_s ui;
  stage_out_s so;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;

  always #25 clk = ~clk;

  useq_model MODEL (.clk(clk), .rst_n(rst_n), .go(go), .cmd(cmd), .ui(ui));

  ustore_stage DUT (
    .clk(clk), .rst_n(rst_n), .ce(ce), .ui(ui), .stage_out(so),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  // Present one word, let the stage take it, then sample the results.
  task automatic step(input shift_e sh, input store_e st,
                      input logic [15:0] t);
    @(posedge clk);
    cmd.shift <= sh;
    cmd.store <= st;
    cmd.t_bus <= t;
    go        <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (awvalid && awready) begin aw_ok = 1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_ok = 1; wvalid <= 1'b0; end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    chk(so.u_bus, WORD_RESET);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // ***************************************************************
    // Shift codes, with the no-operation store
    // ***************************************************************
    foreach (ROWS[i])
    begin
      step(ROWS[i].sh, st_nop, ROWS[i].t);
      chk(so.u_bus, ROWS[i].u);
      chk(so.u_bus, ROWS[i].u);
      chk(so.data_base_reg, 32'h0);
    end
    // ***************************************************************
    // Store codes
    // ***************************************************************
    step(shift_pass, bus_to_scratch0, 16'h1357);
    chk(so.addr_code, 32'h1357);
    chk({so.special_off, so.mcu_on}, 32'h3);
    @(posedge clk);
    #1;
    chk({so.special_off, so.mcu_on}, 32'h0);
    cmd.mcu_data <= 1'b1;
    step(shift_pass, bus_to_scratch1, 16'h0003);
    chk(so.data_code, 32'h0003);
    cmd.mcu_data <= 1'b0;
    step(shift_pass, st_bus_code, 16'h2468);
    chk(so.addr_code, 32'h2468);
    axi_rd(REG_SCRATCH0);
    chk(rd, 32'h1357);
    axi_rd(REG_SCRATCH1);
    chk(rd, 32'h0003);
    step(shift_pass, counter_load_high, 16'h0fc0);
    chk(so.loop_counter_reg, 32'h3f);
    step(shift_pass, counter_load_low, 16'hffd5);
    chk(so.loop_counter_reg, 32'h15);
    step(shift_pass, st_data_base, 16'h1111);
    chk(so.data_base_reg, 32'h1111);
    step(shift_pass, st_data_limit, 16'h2222);
    chk(so.data_limit_reg, 32'h2222);
    step(shift_pass, st_prog_limit, 16'h3333);
    chk(so.program_limit_reg, 32'h3333);
    step(shift_pass, io_word_send, 16'h4444);
    chk(so.direct_output_data_reg, 32'h4444);
    step(shift_pass, io_command_send, 16'h855a);
    chk({so.io_cmd, so.io_dev}, 32'h55a);
    chk({so.io_strobe, so.service_out}, 32'h3);
    @(posedge clk);
    #1;
    chk({so.io_strobe, so.service_out}, 32'h0);
    step(shift_pass, io_command_send, 16'h0200);
    chk({so.io_strobe, so.service_out}, 32'h2);
    chk(so.data_base_reg, 32'h1111);
    // ***************************************************************
    // Stack push, stack store and the following reference
    // ***************************************************************
    step(shift_pass, st_push, 16'ha001);
    step(shift_pass, st_push, 16'ha002);
    axi_rd(REG_TOS1);
    chk(rd, 32'ha001);
    cmd.stack_name <= 2'h2;
    step(shift_pass, stack_cache_store, 16'habcd);
    axi_rd(REG_TOS1);
    chk(rd, 32'habcd);
    axi_rd(REG_TOS0);
    chk(rd, 32'ha002);
    cmd.tos_ref <= 2'h0;
    step(shift_pass, st_nop, 16'h0000);
    chk(so.tos_read, 32'habcd);
    // ***************************************************************
    // Process clock and register bus corners
    // ***************************************************************
    axi_wr(REG_PCLK, 32'h00005a5a);
    chk(resp, RESP_OKAY);
    step(shift_pass, st_pclk, 16'h0000);
    chk(so.sbus, 32'h5a5a);
    axi_wr(REG_DATA_BASE, 32'h0000ffff);
    chk(resp, RESP_OKAY);
    chk(so.data_base_reg, 32'h1111);
    axi_wr(8'h44, 32'h1);
    chk(resp, RESP_DECERR);
    axi_rd(8'h44);
    chk(rd, 32'h0);
    chk(resp, RESP_DECERR);
    axi_rd(REG_COUNTER);
    chk(rd, 32'h15);
    // ***************************************************************
    // Clock enable low and a reset in mid-run
    // ***************************************************************
    @(posedge clk);
    ce <= 1'b0;
    step(shift_pass, st_data_limit, 16'h5555);
    chk(so.data_limit_reg, 32'h2222);
    chk({awready, wready, arready}, 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk(so.data_base_reg, 32'h0);
    chk(so.loop_counter_reg, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    step(shift_pass, st_push, 16'h0042);
    axi_rd(REG_TOS1);
    chk(rd, 32'h0);
    axi_rd(REG_TOS0);
    chk(rd, 32'h42);
    tally_and_finish();
  end

endmodule

`default_nettype wire
